// File: ads_pkg.sv
package ads_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int CHANNELS = 4;

  // printed register numbers are indices; byte address is four times the index
  localparam logic [7:0] IDX_TALLY    = 8'h3F;
  localparam logic [7:0] IDX_RANGE    = 8'h40;
  localparam logic [7:0] IDX_READY    = 8'h41;
  localparam logic [7:0] IDX_FAULT    = 8'h42;
  localparam logic [7:0] IDX_CTRL     = 8'h50;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h51;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h52;

  // control register fields
  localparam int CTRL_TALLY_EN = 0;
  localparam int CTRL_FUSE_EN  = 1;
  localparam int CTRL_W        = 2;

  // internal fault register fields
  localparam int FAULT_FUSE_BIT  = 2;
  localparam int FAULT_SHIFT_BIT = 3;

  // interrupt status and mask fields
  localparam int IRQ_TALLY_DONE = 0;
  localparam int IRQ_RANGE      = 1;
  localparam int IRQ_READY      = 2;
  localparam int IRQ_SHIFT      = 3;
  localparam int IRQ_FUSE       = 4;
  localparam int IRQ_W          = 5;

  localparam logic [CTRL_W-1:0] RST_CTRL = 2'h0;
  localparam logic [IRQ_W-1:0]  RST_MASK = 5'h00;
  localparam logic [IRQ_W-1:0]  RST_STAT = 5'h00;
  localparam logic [7:0]        RST_FLAGS = 8'h00;

  // timing counts in master clock cycles, plus the tally limit and fuse CRC constants
  localparam logic [15:0] TALLY_PRESCALE_CYCLES = 16'd12000;
  localparam logic [7:0]  TALLY_MAX             = 8'hFF;
  localparam logic [9:0]  FUSE_CHECK_CYCLES     = 10'd1000;
  localparam logic [7:0]  FUSE_CRC_POLY         = 8'h07;
  localparam logic [7:0]  FUSE_CRC_INIT         = 8'hFF;

  typedef enum logic [1:0]
  {
    ADS_TALLY_IDLE = 2'b00,
    ADS_TALLY_RUN  = 2'b01,
    ADS_TALLY_FULL = 2'b10
  } ads_tally_e;

  typedef struct packed
  {
    logic                  pready;
    logic                  pslverr;
    logic [DATA_W-1:0]     prdata;
    logic [CTRL_W-1:0]     ctrl;
    logic [IRQ_W-1:0]      irqStat;
    logic [IRQ_W-1:0]      irqMask;
    logic                  irq;
    logic [CHANNELS-1:0]   rangeFault;
    logic [CHANNELS-1:0]   filterReady;
    logic                  shiftSlow;
    logic                  fusePrev;
  } ads_top_s;

endpackage

// File: ads_tally.sv
`timescale 1ns/100ps
module ads_tally
  import ads_pkg::*;
#(
  parameter logic [15:0] PRESCALE = ads_pkg::TALLY_PRESCALE_CYCLES
)
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  output logic [7:0]      count,
  output logic            done
);

  typedef struct packed
  {
    ads_tally_e  state;
    logic [15:0] prescale;
    logic [7:0]  count;
    logic        enPrev;
    logic        done;
  } ads_tally_s;

  ads_tally_s s;
  ads_tally_s next_s;

  always_comb
  begin
    next_s        = s;
    next_s.done   = 1'b0;
    next_s.enPrev = enable;
    case (s.state)
      ADS_TALLY_IDLE:
      begin
        // a fresh run needs a new rising edge of the enable
        if (enable && !s.enPrev)
        begin
          next_s.count    = 8'h00;
          next_s.prescale = 16'h0000;
          next_s.state    = ADS_TALLY_RUN;
        end
      end
      ADS_TALLY_RUN:
      begin
        if (!enable)
        begin
          next_s.state = ADS_TALLY_IDLE;
        end
        else if (s.prescale == PRESCALE - 16'd1)
        begin
          next_s.prescale = 16'h0000;
          next_s.count    = s.count + 8'h01;
          if (s.count + 8'h01 == TALLY_MAX)
          begin
            next_s.state = ADS_TALLY_FULL;
            next_s.done  = 1'b1;
          end
        end
        else
        begin
          next_s.prescale = s.prescale + 16'd1;
        end
      end
      ADS_TALLY_FULL:
      begin
        if (!enable)
        begin
          next_s.state = ADS_TALLY_IDLE;
        end
      end
      default:
      begin
        next_s.state = ADS_TALLY_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '{ADS_TALLY_IDLE, 16'h0000, 8'h00, 1'b0, 1'b0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign count = s.count;
  assign done  = s.done;

endmodule

// File: ads_fuse_check.sv
`timescale 1ns/100ps
module ads_fuse_check
  import ads_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        enable,
  input  wire logic [31:0] fuseData,
  output logic             fuseError
);

  typedef struct packed
  {
    logic       enPrev;
    logic [7:0] refCrc;
    logic [9:0] timer;
    logic       error;
  } ads_fuse_s;

  ads_fuse_s s;
  ads_fuse_s next_s;

  function automatic logic [7:0] crc8(input logic [31:0] word);
    logic [7:0] c;
    c = FUSE_CRC_INIT;
    for (int i = 31; i >= 0; i--)
    begin
      if (c[7] ^ word[i])
        c = {c[6:0], 1'b0} ^ FUSE_CRC_POLY;
      else
        c = {c[6:0], 1'b0};
    end
    return c;
  endfunction

  always_comb
  begin
    next_s        = s;
    next_s.enPrev = enable;
    if (enable && !s.enPrev)
    begin
      // arm: take the reference and start clean
      next_s.refCrc = crc8(fuseData);
      next_s.timer  = 10'd0;
      next_s.error  = 1'b0;
    end
    else if (enable)
    begin
      if (s.timer == FUSE_CHECK_CYCLES - 10'd1)
      begin
        next_s.timer = 10'd0;
        if (crc8(fuseData) != s.refCrc)
        begin
          next_s.error = 1'b1;
        end
      end
      else
      begin
        next_s.timer = s.timer + 10'd1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '{1'b0, 8'h00, 10'd0, 1'b0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign fuseError = s.error;

endmodule

// File: ads_diag_regs.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
// Contract
// - An 8-bit read-only tally advances by one every 12,000 master clock cycles.
// - The tally starts when its enable bit is set and stops once it reaches 255.
// - Software reads the tally value in bits 7 to 0.
// - Bits 3..0 of the filter overflow register show each channel's filter range fault.
// - Bits 3..0 of the filter settled register show each channel's filter ready state.
// - Bit 3 of the internal fault register is set when the shift clock is too slow.
// - With fuse checking on, a fuse CRC change sets bit 2 of the internal fault register.
module ads_diag_regs
  import ads_pkg::*;
#(
  parameter logic [15:0] TALLY_PRESCALE = ads_pkg::TALLY_PRESCALE_CYCLES
)
(
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [ads_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [ads_pkg::DATA_W-1:0]    pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [ads_pkg::DATA_W-1:0]    prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [ads_pkg::CHANNELS-1:0]  filterRangeFault,
  input  wire logic [ads_pkg::CHANNELS-1:0]  filterReady,
  input  wire logic [7:0]                    shiftClockDivide,
  input  wire logic [9:0]                    frameBitCount,
  input  wire logic [15:0]                   framePeriodCycles,
  input  wire logic [31:0]                   fuseData,
  output logic                               irq
);

  ads_top_s s;
  ads_top_s next_s;

  logic [7:0] tallyCount;
  logic       tallyDone;
  logic       fuseError;

  logic                 mapped;
  logic [7:0]           regIdx;
  logic [DATA_W-1:0]    readWord;
  logic [IRQ_W-1:0]     events;
  logic [IRQ_W-1:0]     clearBits;
  logic                 accessDone;
  logic                 shiftSlowNow;

  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    isMapped = (addr[1:0] == 2'b00) && (addr[ADDR_W-1:10] == '0) &&
               (idx == IDX_TALLY || idx == IDX_RANGE || idx == IDX_READY ||
                idx == IDX_FAULT || idx == IDX_CTRL || idx == IDX_IRQ_STAT ||
                idx == IDX_IRQ_MASK);
  endfunction

  // a frame needs divide * bits master cycles; it must fit in one output period
  function automatic logic frameTooLong(input logic [7:0]  divide,
                                        input logic [9:0]  bits,
                                        input logic [15:0] period);
    logic [17:0] need;
    need = 18'(divide * bits);
    frameTooLong = need > {2'b00, period};
  endfunction

  ads_tally #(
    .PRESCALE (TALLY_PRESCALE)
  ) uTally (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .enable (s.ctrl[CTRL_TALLY_EN]),
    .count  (tallyCount),
    .done   (tallyDone)
  );

  ads_fuse_check uFuse (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .enable    (s.ctrl[CTRL_FUSE_EN]),
    .fuseData  (fuseData),
    .fuseError (fuseError)
  );

  always_comb
  begin
    regIdx       = paddr[9:2];
    mapped       = isMapped(paddr);
    shiftSlowNow = frameTooLong(shiftClockDivide, frameBitCount, framePeriodCycles);
    readWord     = '0;
    case (regIdx)
      IDX_TALLY:
      begin
        readWord[7:0] = tallyCount;
      end
      IDX_RANGE:
      begin
        readWord[CHANNELS-1:0] = s.rangeFault;
      end
      IDX_READY:
      begin
        readWord[CHANNELS-1:0] = s.filterReady;
      end
      IDX_FAULT:
      begin
        readWord[FAULT_SHIFT_BIT] = s.shiftSlow;
        readWord[FAULT_FUSE_BIT]  = fuseError;
      end
      IDX_CTRL:
      begin
        readWord[CTRL_W-1:0] = s.ctrl;
      end
      IDX_IRQ_STAT:
      begin
        readWord[IRQ_W-1:0] = s.irqStat;
      end
      IDX_IRQ_MASK:
      begin
        readWord[IRQ_W-1:0] = s.irqMask;
      end
      default:
      begin
        readWord = '0;
      end
    endcase
  end

  always_comb
  begin
    next_s = s;
    next_s.fusePrev    = fuseError;
    next_s.rangeFault  = filterRangeFault;
    next_s.filterReady = filterReady;
    next_s.shiftSlow   = shiftSlowNow;

    // one wait state keeps prdata, pready and pslverr straight from flops
    next_s.pready  = 1'b0;
    // error response stands only with its pready pulse
    next_s.pslverr = 1'b0;
    accessDone     = psel && penable && s.pready;
    if (psel && penable && !s.pready)
    begin
      next_s.pready  = 1'b1;
      next_s.pslverr = !mapped;
      next_s.prdata  = (pwrite || !mapped) ? '0 : readWord;
    end

    // only bits actually returned are cleared, so a late event is never lost
    clearBits = '0;
    if (accessDone && !pwrite && !s.pslverr && regIdx == IDX_IRQ_STAT)
    begin
      clearBits = s.prdata[IRQ_W-1:0];
    end

    // flag registers are read-only: writes there fall through untouched
    if (accessDone && pwrite && !s.pslverr && pstrb[0])
    begin
      case (regIdx)
        IDX_CTRL:
        begin
          next_s.ctrl = pwdata[CTRL_W-1:0];
        end
        IDX_IRQ_MASK:
        begin
          next_s.irqMask = pwdata[IRQ_W-1:0];
        end
        default:
        begin
          next_s.ctrl = s.ctrl;
        end
      endcase
    end

    events                 = '0;
    events[IRQ_TALLY_DONE] = tallyDone;
    events[IRQ_RANGE]      = |(filterRangeFault & ~s.rangeFault);
    events[IRQ_READY]      = |(filterReady & ~s.filterReady);
    events[IRQ_SHIFT]      = shiftSlowNow && !s.shiftSlow;
    events[IRQ_FUSE]       = fuseError && !s.fusePrev;

    // set wins over the read clear
    next_s.irqStat = (s.irqStat & ~clearBits) | events;
    next_s.irq     = |(next_s.irqStat & next_s.irqMask);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s.pready      <= 1'b0;
      s.pslverr     <= 1'b0;
      s.prdata      <= '0;
      s.ctrl        <= RST_CTRL;
      s.irqStat     <= RST_STAT;
      s.irqMask     <= RST_MASK;
      s.irq         <= 1'b0;
      s.rangeFault  <= RST_FLAGS[CHANNELS-1:0];
      s.filterReady <= RST_FLAGS[CHANNELS-1:0];
      s.shiftSlow   <= 1'b0;
      s.fusePrev    <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign irq     = s.irq;

endmodule

// File: ads_diag_regs_asserts.sv
`timescale 1ns/100ps
module ads_diag_regs_asserts
  import ads_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  filterRangeFault,
  input wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_access; psel && $rose(penable); endsequence
  sequence s_wait; !pready ##1 pready; endsequence
  sequence s_rd(a); pready && !pwrite && !pslverr && paddr == a; endsequence
  property p_wait; s_access |-> s_wait; endproperty
  a_wait: assert property (p_wait) else $error("pready not after one wait");
  property p_inacc; pready |-> psel && penable; endproperty
  a_inacc: assert property (p_inacc) else $error("pready outside access");
  property p_errrdy; pslverr |-> pready; endproperty
  a_errrdy: assert property (p_errrdy) else $error("pslverr without pready");
  property p_wrzero; pready && pwrite |-> prdata == 32'h0; endproperty
  a_wrzero: assert property (p_wrzero) else $error("write returned data");
  property p_misal; pready && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  a_misal: assert property (p_misal) else $error("misaligned not refused");
  property p_upper;
    pready && !pwrite && paddr inside {12'h100, 12'h104, 12'h108} |-> prdata[31:4] == 28'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("flag upper bits set");
  property p_tally; s_rd(12'h0FC) |-> prdata[31:8] == 24'h0; endproperty
  a_tally: assert property (p_tally) else $error("tally above 8 bits");
  property p_mirror;
    s_rd(12'h100) ##0 $past(filterRangeFault, 1) == $past(filterRangeFault, 3)
      |-> prdata[3:0] == $past(filterRangeFault, 2);
  endproperty
  a_mirror: assert property (p_mirror) else $error("range flags wrong");
  property p_mask;
    pready && pwrite && !pslverr && paddr == 12'h148 && pstrb[0] && pwdata[4:0] == 5'h0
      |-> ##2 !irq;
  endproperty
  a_mask: assert property (p_mask) else $error("irq with mask clear");
endmodule

bind ads_diag_regs ads_diag_regs_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .filterRangeFault(filterRangeFault),
  .irq(irq));

// File: ads_diag_regs_bench.sv
`timescale 1ns/100ps
module ads_diag_regs_bench;
  import ads_pkg::*;
  localparam logic [15:0] PRE = 16'h0008;
  localparam logic [11:0] A_TALLY = {2'h0, IDX_TALLY, 2'h0};
  localparam logic [11:0] A_RANGE = {2'h0, IDX_RANGE, 2'h0};
  localparam logic [11:0] A_READY = {2'h0, IDX_READY, 2'h0};
  localparam logic [11:0] A_FAULT = {2'h0, IDX_FAULT, 2'h0};
  localparam logic [11:0] A_CTRL  = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] A_STAT  = {2'h0, IDX_IRQ_STAT, 2'h0};
  localparam logic [11:0] A_MASK  = {2'h0, IDX_IRQ_MASK, 2'h0};
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, fuse;
  logic [3:0]  pstrb, rangeIn, readyIn;
  logic [7:0]  divide;
  logic [9:0]  bits;
  logic [15:0] period;
  int          errCount = 0;
  int          comparisons = 0;
  int          cycles = 0;

  ads_diag_regs #(.TALLY_PRESCALE(PRE)) dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .filterRangeFault(rangeIn),
    .filterReady(readyIn), .shiftClockDivide(divide), .frameBitCount(bits),
    .framePeriodCycles(period), .fuseData(fuse), .irq(irq));

  always #5 mclk = ~mclk;

  task automatic print_verdict();
    $display("comparisons=%0d errors=%0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errCount++;
      print_verdict();
    end
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      errCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until pready is sampled high, then released
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // only the bench timeout ends a wait that never gets an answer
    while (pready !== 1'b1)
    begin
      @(posedge mclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    apb(1'b0, a, 32'h0);
    chk32(rdat, exp);
    chk1(rerr, eerr);
  endtask

  task automatic wchk(input logic [11:0] a, input logic [31:0] d, input logic eerr);
    apb(1'b1, a, d);
    chk1(rerr, eerr);
  endtask

  task automatic t_reset();
    rchk(A_TALLY, 32'h0, 1'b0);
    rchk(A_RANGE, 32'h0, 1'b0);
    rchk(A_READY, 32'h0, 1'b0);
    rchk(A_FAULT, 32'h0, 1'b0);
    rchk(12'h200, 32'h0, 1'b1);
    rchk(12'h101, 32'h0, 1'b1);
  endtask

  task automatic t_flags();
    rangeIn <= 4'hA;
    readyIn <= 4'h5;
    repeat (3) @(posedge mclk);
    rchk(A_RANGE, 32'hA, 1'b0);
    rchk(A_READY, 32'h5, 1'b0);
    wchk(A_RANGE, 32'hFFFF_FFFF, 1'b0);
    rchk(A_RANGE, 32'hA, 1'b0);
    chk1(irq, 1'b0);
    wchk(A_MASK, 32'h1F, 1'b0);
    @(posedge mclk);
    chk1(irq, 1'b1);
    rchk(A_STAT, 32'h6, 1'b0);
    @(posedge mclk);
    chk1(irq, 1'b0);
    rchk(A_STAT, 32'h0, 1'b0);
    wchk(A_MASK, 32'h0, 1'b0);
    rangeIn <= 4'h5;
    readyIn <= 4'hA;
    repeat (3) @(posedge mclk);
    rchk(A_RANGE, 32'h5, 1'b0);
    rchk(A_READY, 32'hA, 1'b0);
  endtask

  task automatic t_shift();
    divide <= 8'h04;
    bits <= 10'h00A;
    period <= 16'h0028;
    repeat (3) @(posedge mclk);
    rchk(A_FAULT, 32'h0, 1'b0);
    period <= 16'h0027;
    repeat (3) @(posedge mclk);
    rchk(A_FAULT, 32'h8, 1'b0);
    period <= 16'hFFFF;
  endtask

  task automatic t_fuse();
    wchk(A_CTRL, 32'h2, 1'b0);
    repeat (1100) @(posedge mclk);
    rchk(A_FAULT, 32'h0, 1'b0);
    fuse <= 32'h1234_5679;
    repeat (1100) @(posedge mclk);
    rchk(A_FAULT, 32'h4, 1'b0);
  endtask

  task automatic t_tally();
    wchk(A_MASK, 32'h1, 1'b0);
    apb(1'b0, A_STAT, 32'h0);
    wchk(A_CTRL, 32'h3, 1'b0);
    // reads land mid-period so a one-cycle skew cannot flip the count
    repeat (int'(PRE) * 5) @(posedge mclk);
    rchk(A_TALLY, 32'h5, 1'b0);
    chk1(irq, 1'b0);
    repeat (int'(PRE) * 256) @(posedge mclk);
    rchk(A_TALLY, 32'hFF, 1'b0);
    chk1(irq, 1'b1);
    apb(1'b0, A_STAT, 32'h0);
    chk32(rdat & 32'h1, 32'h1);
    rchk(A_STAT, 32'h0, 1'b0);
    chk1(irq, 1'b0);
  endtask

  initial
  begin
    mclk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    rangeIn = 4'h0;
    readyIn = 4'h0;
    divide = 8'h00;
    bits = 10'h000;
    period = 16'hFFFF;
    fuse = 32'h1234_5678;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_flags();
    t_shift();
    t_fuse();
    t_tally();
    print_verdict();
  end
endmodule
